/* File: logic/bst_tap.sv */
// Boundary-scan test access port: controller, instruction and scan chains.
// What this block does
// [R1] TMS sampled on rising TCK steps the sixteen-state controller.
// [R2] Test inputs sampled on rising TCK, TDO changes on falling TCK.
// [R3] Capture-DR loads the selected register on the edge that leaves it.
// [R4] Shift-DR enables TDO at first falling edge, showing the LSB.
// [R5] Data register shifts on each rising edge while in Shift-DR.
// [R6] TDO floats at the first falling edge in Exit1-DR.
// [R7] Returning to Shift-DR from an exit state keeps the shifted data.
// [R8] Pause-DR holds the partly shifted data indefinitely.
// [R9] Update-DR copies shift stage into holding latches on falling TCK, unless read-back is selected.
// [R10] Capture-IR loads the fixed pattern 10000001.
// [R11] Shift-IR enables TDO at first falling edge, showing the LSB.
// [R12] Instruction register shifts on each rising edge while in Shift-IR.
// [R13] TDO floats at the first falling edge in Exit1-IR.
// [R14] Instruction shift bits kept through exit and pause states.
// [R15] Update-IR makes the shifted instruction current on falling TCK.
// [R16] Shift stage plus holding latch, except bypass and identification.
// [R17] Shift states stream TDI to TDO; capture states parallel-load.
// [R18] The instruction selects mode, operation, scan register, source.
// [R19] Bit 7 is even parity; unsupported or bad opcodes act as bypass.
// [R20] Power-up and reset state set the instruction to 10000001.
// [R21] Boundary chain has 48 cells, one per input or shared I/O pin.
// [R22] Instruction picks the capture source; self test changes cells.
// [R23] Output-enable cells 47 to 44 reset to one.
// [R24] Chain scans from TDI through cell 47 down to cell 0 to TDO.
// [R25] Cells map to enables, clocks, latch enables, A pins, B pins.
// [R26] TDO floats in every state except the two shift states.
`timescale 1ns/10ps
module bst_tap #(
    parameter logic [31:0] ID_CODE = bst_pkg::ID_DEFAULT
) (
    // System clock and synchronous active-low reset.
    input wire logic MCLK,
    input wire logic RST_N,
    // Test access port.
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    // Pin levels seen by the boundary cells.
    input wire logic [3:0] OE_PINS_IN,
    input wire logic [3:0] CLK_PINS_IN,
    input wire logic [3:0] LE_PINS_IN,
    input wire logic [17:0] A_PINS_IN,
    input wire logic [17:0] B_PINS_IN,
    // Holding latches and test mode, in the system clock domain.
    output logic [47:0] CELL_LATCH,
    output logic TEST_MODE,
    output logic HIGHZ_MODE
);
    // Reset carried into the test clock domain.
    logic rst_t1;
    logic rst_t2;
    // Controller state.
    bst_pkg::bst_state_e state;
    bst_pkg::bst_state_e next_state;
    // Shift stages and holding latches.
    logic [7:0] ir_shift;
    logic [7:0] ir_cur;
    logic [47:0] chain_shift;
    // Holding latches, split so that each part has a single process.
    logic [3:0] latch_oe;
    logic [43:0] latch_rest;
    wire [47:0] chain_latch = {latch_oe, latch_rest};
    logic [31:0] id_shift;
    logic bypass_bit;
    // Pin levels after two flip-flops.
    logic [47:0] pin_s1;
    logic [47:0] pin_s2;
    // Falling-edge outputs and update event toggle.
    logic tdo_q;
    logic tdo_oe_q;
    logic upd_tog;
    // System-side crossing.
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [47:0] latch_q;
    logic mode_q;
    logic highz_q;

    // The power-up reset reaches the test clock domain through two flops.
    always_ff @(posedge TCK) begin
        rst_t1 <= RST_N;
        rst_t2 <= rst_t1;
    end

    // Controller stepping, per the standard state diagram.
    always_comb begin
        next_state = state;
        case (state)
            bst_pkg::ST_RESET: begin
                next_state = TMS ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
            end
            bst_pkg::ST_IDLE: begin
                next_state = TMS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            end
            bst_pkg::ST_SEL_DR: begin
                next_state = TMS ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
            end
            bst_pkg::ST_CAP_DR: begin
                next_state = TMS ? bst_pkg::ST_EXIT1_DR
                                 : bst_pkg::ST_SHIFT_DR;
            end
            bst_pkg::ST_SHIFT_DR: begin
                next_state = TMS ? bst_pkg::ST_EXIT1_DR
                                 : bst_pkg::ST_SHIFT_DR;
            end
            bst_pkg::ST_EXIT1_DR: begin
                next_state = TMS ? bst_pkg::ST_UPD_DR
                                 : bst_pkg::ST_PAUSE_DR;
            end
            bst_pkg::ST_PAUSE_DR: begin
                next_state = TMS ? bst_pkg::ST_EXIT2_DR
                                 : bst_pkg::ST_PAUSE_DR;
            end
            bst_pkg::ST_EXIT2_DR: begin
                next_state = TMS ? bst_pkg::ST_UPD_DR
                                 : bst_pkg::ST_SHIFT_DR;
            end
            bst_pkg::ST_UPD_DR: begin
                next_state = TMS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            end
            bst_pkg::ST_SEL_IR: begin
                next_state = TMS ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
            end
            bst_pkg::ST_CAP_IR: begin
                next_state = TMS ? bst_pkg::ST_EXIT1_IR
                                 : bst_pkg::ST_SHIFT_IR;
            end
            bst_pkg::ST_SHIFT_IR: begin
                next_state = TMS ? bst_pkg::ST_EXIT1_IR
                                 : bst_pkg::ST_SHIFT_IR;
            end
            bst_pkg::ST_EXIT1_IR: begin
                next_state = TMS ? bst_pkg::ST_UPD_IR
                                 : bst_pkg::ST_PAUSE_IR;
            end
            bst_pkg::ST_PAUSE_IR: begin
                next_state = TMS ? bst_pkg::ST_EXIT2_IR
                                 : bst_pkg::ST_PAUSE_IR;
            end
            bst_pkg::ST_EXIT2_IR: begin
                next_state = TMS ? bst_pkg::ST_UPD_IR
                                 : bst_pkg::ST_SHIFT_IR;
            end
            bst_pkg::ST_UPD_IR: begin
                next_state = TMS ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            end
            default: begin
                next_state = bst_pkg::ST_RESET;
            end
        endcase
    end

    // State register; TMS is taken on the rising edge only.
    always_ff @(posedge TCK) begin
        if (!rst_t2) begin
            state <= bst_pkg::ST_RESET;
        end else begin
            state <= next_state; // [R1] [R2]
        end
    end

    // Instruction decode from the current (held) instruction.
    wire parity_ok = ~^ir_cur; // [R19]
    wire op_extest = parity_ok && ir_cur == bst_pkg::OP_EXTEST;
    wire op_idcode = parity_ok && ir_cur == bst_pkg::OP_IDCODE;
    wire op_sample = parity_ok && ir_cur == bst_pkg::OP_SAMPLE;
    wire op_highz = parity_ok && ir_cur == bst_pkg::OP_HIGHZ;
    wire op_clamp = parity_ok && ir_cur == bst_pkg::OP_CLAMP;
    wire op_runt = parity_ok && ir_cur == bst_pkg::OP_RUNT;
    wire op_readbn = parity_ok && ir_cur == bst_pkg::OP_READBN;
    wire op_readbt = parity_ok && ir_cur == bst_pkg::OP_READBT;
    wire op_celltst = parity_ok && ir_cur == bst_pkg::OP_CELLTST;
    // Register selection; everything else falls to bypass.
    wire sel_chain = op_extest | op_sample | op_readbn | op_readbt
                   | op_celltst; // [R18]
    wire sel_id = op_idcode;
    wire sel_read = op_readbn | op_readbt; // [R22]
    wire sel_update = op_extest | op_sample | op_celltst;
    wire test_mode = op_extest | op_highz | op_clamp | op_runt
                   | op_readbt; // [R18]

    // State qualifiers for the scan paths.
    wire in_reset = state == bst_pkg::ST_RESET;
    wire in_cap_dr = state == bst_pkg::ST_CAP_DR;
    wire in_shift_dr = state == bst_pkg::ST_SHIFT_DR;
    wire in_cap_ir = state == bst_pkg::ST_CAP_IR;
    wire in_shift_ir = state == bst_pkg::ST_SHIFT_IR;
    wire in_idle = state == bst_pkg::ST_IDLE;
    // Entering reset restores the instruction and enables, so the system
    // side is told once; later reset cycles change nothing and stay quiet.
    wire reset_event = in_reset
                     && (ir_cur != bst_pkg::IR_RESET
                         || latch_oe != bst_pkg::OE_RESET); // [R20]

    // Pin levels gathered in chain order, cell 47 first.
    wire [47:0] pin_word = {OE_PINS_IN, CLK_PINS_IN, LE_PINS_IN,
                            A_PINS_IN, B_PINS_IN}; // [R21] [R25]
    // Capture source for the boundary chain.
    wire [47:0] chain_src = sel_read ? chain_latch : pin_s2; // [R22]

    // Pins are asynchronous to the test clock, so two flops first.
    always_ff @(posedge TCK) begin
        pin_s1 <= pin_word;
        pin_s2 <= pin_s1;
    end

    // Instruction shift stage; exit and pause states simply hold it.
    always_ff @(posedge TCK) begin
        if (!rst_t2 || in_reset) begin
            ir_shift <= bst_pkg::IR_RESET;
        end else if (in_cap_ir) begin
            ir_shift <= bst_pkg::IR_CAPTURE; // [R10] [R17]
        end else if (in_shift_ir) begin
            ir_shift <= {TDI, ir_shift[7:1]}; // [R12] [R14]
        end
    end

    // Boundary chain shift stage, TDI enters at cell 47.
    always_ff @(posedge TCK) begin
        if (!rst_t2) begin
            chain_shift <= bst_pkg::CHAIN_RESET;
        end else if (in_cap_dr && sel_chain) begin
            chain_shift <= chain_src; // [R3] [R17]
        end else if (in_shift_dr && sel_chain) begin
            chain_shift <= {TDI, chain_shift[47:1]}; // [R5] [R24]
        end
    end

    // Identification and bypass have a shift stage only.
    always_ff @(posedge TCK) begin
        if (in_cap_dr) begin
            id_shift <= ID_CODE; // [R16] [R3]
            bypass_bit <= 1'b0;
        end else if (in_shift_dr) begin
            id_shift <= {TDI, id_shift[31:1]}; // [R5] [R7] [R8]
            bypass_bit <= TDI;
        end
    end

    // Bit presented at TDO: the LSB of whichever path is selected.
    wire dr_bit = sel_chain ? chain_shift[0]
                : (sel_id ? id_shift[0] : bypass_bit);
    wire scan_bit = in_shift_ir ? ir_shift[0] : dr_bit; // [R4] [R11]

    // Falling edge: TDO, current instruction and holding latches.
    // Doing the updates here keeps them a half cycle clear of the
    // rising-edge shift, as the controller expects.
    always_ff @(negedge TCK) begin
        if (!rst_t2) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            // Outside the shift states the selected register may never
            // have been captured, so a fixed level is parked instead.
            tdo_q <= (in_shift_dr | in_shift_ir) ? scan_bit : 1'b0; // [R2]
            tdo_oe_q <= in_shift_dr | in_shift_ir; // [R6] [R13] [R26]
        end
    end

    // Current instruction, reset in the reset state.
    always_ff @(negedge TCK) begin
        if (!rst_t2 || in_reset) begin
            ir_cur <= bst_pkg::IR_RESET; // [R20]
        end else if (state == bst_pkg::ST_UPD_IR) begin
            ir_cur <= ir_shift; // [R15]
        end
    end

    // Boundary holding latches; only enable cells have a reset value.
    always_ff @(negedge TCK) begin
        if (!rst_t2 || in_reset) begin
            latch_oe <= bst_pkg::OE_RESET; // [R23]
        end else if (state == bst_pkg::ST_UPD_DR && sel_update) begin
            latch_oe <= chain_shift[47:44]; // [R9]
        end else if (in_idle && op_celltst) begin
            latch_oe <= chain_shift[47:44]; // [R22]
        end
    end

    // Remaining cells carry no reset, their start value is unknown.
    always_ff @(negedge TCK) begin
        if (state == bst_pkg::ST_UPD_DR && sel_update) begin
            latch_rest <= chain_shift[43:0]; // [R9] [R16]
        end else if (in_idle && op_celltst) begin
            latch_rest <= chain_shift[43:0]; // [R22]
        end
    end

    // Event toggle: flips after each latch or instruction update.
    always_ff @(negedge TCK) begin
        if (!rst_t2) begin
            upd_tog <= 1'b0;
        end else if (state == bst_pkg::ST_UPD_DR
                     || state == bst_pkg::ST_UPD_IR
                     || (in_idle && op_celltst)
                     || reset_event) begin
            upd_tog <= ~upd_tog; // [R20]
        end
    end

    // Pad driving: TDO floats (enable low) outside shift states.
    assign TDO = tdo_q;
    assign TDO_OE = tdo_oe_q;

    // Toggle synchroniser into the system clock domain.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= upd_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // Latches and mode are stable for several test clocks after a
    // toggle, so they are copied once the toggle has settled.
    // Limitation: self test in idle updates every test clock, which is
    // slower than the copy only while the test clock stays below MCLK/3.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            latch_q <= bst_pkg::CHAIN_RESET;
            mode_q <= 1'b0;
            highz_q <= 1'b0;
        end else if (tog_s2 != tog_s3) begin
            latch_q <= chain_latch;
            mode_q <= test_mode;
            highz_q <= op_highz;
        end
    end

    // System-side outputs, all from flip-flops.
    assign CELL_LATCH = latch_q;
    assign TEST_MODE = mode_q;
    assign HIGHZ_MODE = highz_q;
endmodule : bst_tap

/* File: logic/bst_pkg.sv */
// Constants and types shared by the boundary-scan test access logic.
package bst_pkg;
    // Test access port controller states, binary coded.
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPD_IR = 4'hF
    } bst_state_e;

    // Register lengths.
    localparam int IR_W = 8;
    localparam int CHAIN_W = 48;
    localparam int ID_W = 32;

    // Instruction capture pattern and reset opcode.
    localparam logic [7:0] IR_CAPTURE = 8'h81;
    localparam logic [7:0] IR_RESET = 8'h81;

    // Supported opcodes, bit 7 completing even parity.
    localparam logic [7:0] OP_EXTEST = 8'h00;
    localparam logic [7:0] OP_IDCODE = 8'h81;
    localparam logic [7:0] OP_SAMPLE = 8'h82;
    localparam logic [7:0] OP_HIGHZ = 8'h06;
    localparam logic [7:0] OP_CLAMP = 8'h87;
    localparam logic [7:0] OP_RUNT = 8'h09;
    localparam logic [7:0] OP_READBN = 8'h0A;
    localparam logic [7:0] OP_READBT = 8'h8B;
    localparam logic [7:0] OP_CELLTST = 8'h0C;

    // Chain field positions, most significant cell first.
    localparam int OE_LSB = 44;
    localparam int CLK_LSB = 40;
    localparam int LE_LSB = 36;
    localparam int A_LSB = 18;
    localparam int B_LSB = 0;

    // Output-enable cells reset to one; the rest reset to zero here.
    localparam logic [3:0] OE_RESET = 4'hF;
    localparam logic [47:0] CHAIN_RESET = 48'hF000_0000_0000;

    // Identification value; arbitrary neutral value with bit 0 set.
    localparam logic [31:0] ID_DEFAULT = 32'h0000_1001;
endpackage : bst_pkg

/* File: verification/bst_tap_props.sv */
// Concurrent checks on the scan port and the system-side outputs.
`timescale 1ns/10ps
module bst_tap_props (
    // System side.
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [47:0] CELL_LATCH,
    input wire logic TEST_MODE,
    input wire logic HIGHZ_MODE,
    // Scan port.
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDO,
    input wire logic TDO_OE
);
    logic [3:0] st;
    logic tdo_rise;
    logic oe_rise;

    // One step of the controller; IR states sit seven codes above DR ones.
    function automatic logic [3:0] step(input logic [3:0] s, input logic m);
        logic [3:0] o;
        logic [3:0] r;
        o = (s >= 4'hA) ? 4'h7 : 4'h0;
        r = s - o;
        case (r)
            4'h0: return m ? 4'h0 : 4'h1;
            4'h1, 4'h8: return m ? 4'h2 : 4'h1;
            4'h2: return m ? 4'h9 : 4'h3;
            4'h9: return m ? 4'h0 : 4'hA;
            4'h3, 4'h4: return (m ? 4'h5 : 4'h4) + o;
            4'h5: return (m ? 4'h8 : 4'h6) + o;
            4'h6: return (m ? 4'h7 : 4'h6) + o;
            default: return (m ? 4'h8 : 4'h4) + o;
        endcase
    endfunction : step

    // Reference state; TMS is held high around reset, so no sync is needed.
    always_ff @(posedge TCK) begin
        if (!RST_N) begin
            st <= 4'h0;
        end else begin
            st <= step(st, TMS);
        end
    end

    // Port levels as seen at each rising edge.
    always_ff @(posedge TCK) begin
        tdo_rise <= TDO;
        oe_rise <= TDO_OE;
    end

    chk_oe_dr_shift: assert property (@(posedge TCK)
        disable iff (!RST_N)
        st == bst_pkg::ST_SHIFT_DR |-> TDO_OE)
        else $error("TDO not driven in data shift");
    chk_oe_ir_shift: assert property (@(posedge TCK)
        disable iff (!RST_N)
        st == bst_pkg::ST_SHIFT_IR |-> TDO_OE)
        else $error("TDO not driven in instruction shift");
    chk_oe_float: assert property (@(posedge TCK)
        disable iff (!RST_N)
        !(st inside {bst_pkg::ST_SHIFT_DR, bst_pkg::ST_SHIFT_IR}) |-> !TDO_OE)
        else $error("TDO driven outside shift states");
    chk_ir_capture: assert property (@(posedge TCK)
        disable iff (!RST_N)
        (st == bst_pkg::ST_SHIFT_IR && $past(st) == bst_pkg::ST_CAP_IR)
        |-> TDO ##1 (st != bst_pkg::ST_SHIFT_IR || !TDO))
        else $error("instruction capture pattern wrong");
    chk_tdo_falling: assert property (@(negedge TCK)
        disable iff (!RST_N)
        TDO == tdo_rise && TDO_OE == oe_rise)
        else $error("TDO changed on a rising edge");
    chk_reset_values: assert property (@(posedge MCLK)
        disable iff (!RST_N)
        $rose(RST_N) |-> CELL_LATCH == bst_pkg::CHAIN_RESET && !TEST_MODE)
        else $error("outputs not at reset values");
    chk_highz_test: assert property (@(posedge MCLK)
        disable iff (!RST_N)
        HIGHZ_MODE |-> TEST_MODE)
        else $error("high impedance mode outside test mode");
    chk_tlr_normal: assert property (@(posedge MCLK)
        disable iff (!RST_N)
        (st == bst_pkg::ST_RESET) [*8] |-> !TEST_MODE && &CELL_LATCH[47:44])
        else $error("controller reset did not restore instruction");
endmodule : bst_tap_props

bind bst_tap bst_tap_props chk_u (.MCLK(MCLK), .RST_N(RST_N),
    .CELL_LATCH(CELL_LATCH), .TEST_MODE(TEST_MODE), .HIGHZ_MODE(HIGHZ_MODE),
    .TCK(TCK), .TMS(TMS), .TDO(TDO), .TDO_OE(TDO_OE));

/* File: verification/bst_ctl_model.sv */
// Behavioural board test controller driving the scan port.
`timescale 1ns/10ps
module bst_ctl_model (
    // Scan port toward the device.
    output logic TCK,
    output logic TMS,
    output logic TDI,
    input wire logic TDO,
    input wire logic TDO_OE
);
    // Clock stands low between frames; pulled-up lines idle high.
    initial begin
        TCK = 1'b0;
        TMS = 1'b1;
        TDI = 1'b1;
    end

    // One test clock; TDO is a floating wire unless enabled.
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        TMS = tms;
        TDI = tdi;
        #24 TCK = 1'b1;
        tdo = TDO_OE ? TDO : 1'bz;
        #24 TCK = 1'b0;
    endtask : tick

    // Full scan from Idle; optional pause after bit pause_at.
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
        input int pause_at, output logic [63:0] dout);
        logic b;
        dout = '0;
        #7;
        tick(1'b1, 1'b1, b);
        if (ir) begin
            tick(1'b1, 1'b1, b);
        end
        tick(1'b0, 1'b1, b);
        tick(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1 || i == pause_at, din[i], b);
            dout[i] = b;
            if (i == pause_at && i != n - 1) begin
                tick(1'b0, 1'b1, b);
                tick(1'b0, 1'b1, b);
                tick(1'b1, 1'b1, b);
                tick(1'b0, 1'b1, b);
            end
        end
        tick(1'b1, 1'b1, b);
        tick(1'b0, 1'b1, b);
    endtask : scan

    // Long enough in reset for the system side to follow.
    task automatic reset_tap();
        logic b;
        #7;
        repeat (10) tick(1'b1, 1'b1, b);
        tick(1'b0, 1'b1, b);
    endtask : reset_tap
endmodule : bst_ctl_model

/* File: verification/bst_tap_tb_top.sv */
// Self-checking bench for the boundary-scan access logic.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bst_tap_tb_top;
    localparam logic [47:0] PINS = 48'hA5C9_6A8F_1C3A;
    localparam logic [47:0] P2 = 48'h9E37_79B9_7F4A;
    localparam logic [87:0] OPS = 88'h00_0687_098B_0A0C_8281_0301;
    localparam logic [10:0] TMX = 11'h7C0;
    logic mclk;
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic test_mode;
    logic highz_mode;
    logic [47:0] pins;
    logic [47:0] cell_latch;
    logic [63:0] got;
    int err_count = 0;
    int compares = 0;

    // System clock.
    always #20 mclk = ~mclk;

    bst_tap dut_u (.MCLK(mclk), .RST_N(rst_n), .TCK(tck), .TMS(tms),
        .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .OE_PINS_IN(pins[47:44]),
        .CLK_PINS_IN(pins[43:40]), .LE_PINS_IN(pins[39:36]),
        .A_PINS_IN(pins[35:18]), .B_PINS_IN(pins[17:0]),
        .CELL_LATCH(cell_latch), .TEST_MODE(test_mode),
        .HIGHZ_MODE(highz_mode));
    bst_ctl_model ctl_u (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_OE(tdo_oe));

    // The system-side copy lags an update by up to three cycles.
    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask : settle

    task automatic t_reset();
        logic b;
        @(posedge mclk);
        pins <= PINS;
        #7;
        repeat (3) ctl_u.tick(1'b1, 1'b1, b);
        @(posedge mclk);
        `CHK(cell_latch, 48'hF000_0000_0000)
        `CHK({test_mode, highz_mode, tdo_oe}, 3'h0)
        rst_n <= 1'b1;
        ctl_u.reset_tap();
        ctl_u.scan(1'b0, 32, 64'h0, -1, got);
        `CHK(got[31:0], bst_pkg::ID_DEFAULT)
        $display("reset test done");
    endtask : t_reset

    // Sample pins with a paused scan, then preload the latches.
    task automatic t_sample();
        ctl_u.scan(1'b1, 8, 64'h82, -1, got);
        `CHK(got[7:0], 8'h81)
        ctl_u.scan(1'b0, 48, {16'h0, P2}, 20, got);
        `CHK(got[47:0], PINS)
        settle();
        `CHK(cell_latch, P2)
        `CHK(test_mode, 1'b0)
        // Read-back captures the holding latches, not the pins; the
        // zeros shifted in here feed the self-test copy further on.
        ctl_u.scan(1'b1, 8, 64'h0A, -1, got);
        ctl_u.scan(1'b0, 48, 64'h0, -1, got);
        `CHK(got[47:0], P2)
        $display("sample test done");
    endtask : t_sample

    task automatic t_modes();
        for (int i = 0; i < 11; i++) begin
            ctl_u.scan(1'b1, 8, {56'h0, OPS[8*(10-i) +: 8]}, -1, got);
            `CHK(got[7:0], 8'h81)
            settle();
            `CHK(test_mode, TMX[10-i])
            `CHK(highz_mode, i == 1)
            if (i == 6) begin
                `CHK(cell_latch, 48'h0)
            end
        end
        $display("mode test done");
    endtask : t_modes

    // A wrong-parity opcode and an unsupported opcode both give one cell.
    task automatic t_bypass();
        for (int i = 0; i < 2; i++) begin
            ctl_u.scan(1'b1, 8, (i == 0) ? 64'h1 : 64'h3, -1, got);
            ctl_u.scan(1'b0, 4, 64'hB, -1, got);
            `CHK(got[3:0], 4'h6)
        end
        $display("bypass test done");
    endtask : t_bypass

    task automatic t_tlr();
        ctl_u.scan(1'b1, 8, 64'h0, 3, got);
        `CHK(got[7:0], 8'h81)
        settle();
        `CHK(test_mode, 1'b1)
        ctl_u.reset_tap();
        settle();
        `CHK(test_mode, 1'b0)
        `CHK(cell_latch[47:44], 4'hF)
        ctl_u.scan(1'b0, 32, 64'h0, 7, got);
        `CHK(got[31:0], bst_pkg::ID_DEFAULT)
        $display("controller reset test done");
    endtask : t_tlr

    task automatic final_report();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // Main sequence.
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        pins = '0;
        t_reset();
        t_sample();
        t_modes();
        t_bypass();
        t_tlr();
        final_report();
    end

    // The scans need well under a tenth of this span.
    initial begin
        #400_000;
        err_count++;
        final_report();
    end
endmodule : bst_tap_tb_top
